//--- rtl/frs_defs.vh
// Constants for the frequency reference selector
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH
`define FRS_FW            16
`define FRS_CH_PANEL      2'h0
`define FRS_CH_TERM       2'h1
`define FRS_CH_HOST       2'h2
`define FRS_SRC_VOLATILE  4'h0
`define FRS_SRC_RETAINED  4'h1
`define FRS_SRC_VAIN      4'h2
`define FRS_SRC_SAIN      4'h3
`define FRS_SRC_KNOB      4'h4
`define FRS_SRC_PULSE     4'h5
`define FRS_SRC_MULTI     4'h6
`define FRS_SRC_SEQ       4'h7
`define FRS_SRC_PID       4'h8
`define FRS_SRC_COMM      4'h9
`define FRS_UNIT_X        4'h0
`define FRS_UNIT_COMB     4'h1
`define FRS_UNIT_XY       4'h2
`define FRS_UNIT_XXY      4'h3
`define FRS_UNIT_YXY      4'h4
`define FRS_OP_ADD        4'h0
`define FRS_OP_SUB        4'h1
`define FRS_OP_MAX        4'h2
`define FRS_OP_MIN        4'h3
`define FRS_CURVES        5
`define FRS_STEPS         16
`define FRS_CLK_HZ        50000000
`define FRS_GATE_MS       10
`define FRS_GATE_CYC      (`FRS_CLK_HZ / 1000 * `FRS_GATE_MS)
`define FRS_PULSE_MAX_HZ  100000
`define FRS_PULSE_FS      (`FRS_PULSE_MAX_HZ * `FRS_GATE_MS / 1000)
`define FRS_UPDN_MS       20
`define FRS_UPDN_CYC      (`FRS_CLK_HZ / 1000 * `FRS_UPDN_MS)
`define FRS_SEQ_TICK_MS   100
`define FRS_SEQ_TICK_CYC  (`FRS_CLK_HZ / 1000 * `FRS_SEQ_TICK_MS)
`endif

//--- rtl/frs_pulse_meter.v
// Pulse rate meter on the pulse-capable digital input
`timescale 1ns/1ns
`include "frs_defs.vh"
module frs_pulse_meter #(
   parameter GATE_CYC = `FRS_GATE_CYC
) (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        pulseIn,
   output reg  [15:0] pulseCount_q,
   output reg         countValid_q
);
   reg  [1:0]  syncQ;
   reg         lastQ;
   reg  [15:0] edgeCntQ;
   reg  [31:0] gateCntQ;
   wire        rise = syncQ[1] & ~lastQ;
   wire        gateEnd = (gateCntQ == GATE_CYC - 1);

   // Two stages before any edge logic; pin is asynchronous
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         syncQ        <= 2'h0;
         lastQ        <= 1'b0;
         edgeCntQ     <= 16'h0;
         gateCntQ     <= 32'h0;
         pulseCount_q <= 16'h0;
         countValid_q <= 1'b0;
      end else begin
         syncQ        <= {syncQ[0], pulseIn};
         lastQ        <= syncQ[1];
         countValid_q <= gateEnd;
         if (gateEnd) begin
            gateCntQ     <= 32'h0;
            pulseCount_q <= edgeCntQ + {15'h0, rise};
            edgeCntQ     <= 16'h0;
         end else begin
            gateCntQ <= gateCntQ + 32'h1;
            // Saturate rather than wrap, except that an edge in the gate-end cycle wraps a saturated count to 0
            if (rise && edgeCntQ != 16'hffff)
               edgeCntQ <= edgeCntQ + 16'h1;
         end
      end
   end
endmodule // frs_pulse_meter

//--- rtl/frs_frequency_selector.v
// Frequency reference selector: command channel, X/Y sources and combination
// What this block does
// R01 - Channel 1: run, direction and jog come only from input terminals
// R02 - Channel 2: run and direction come from the serial host
// R03 - Source setting defaults 00; units 0 uses X alone
// R04 - Units 1: target is X combined with Y per tens digit
// R05 - Units 2: X when switch terminal inactive, Y when active
// R06 - Units 3: X when switch inactive, combination when active
// R07 - Units 4: Y when switch inactive, combination when active
// R08 - Tens 0: combination is X plus Y
// R09 - Tens 1: combination is X minus Y
// R10 - Tens 2: combination is operand with larger magnitude
// R11 - Tens 3: combination is operand with smaller magnitude
// R12 - Source codes 0..9 map to the ten listed inputs, default 0
// R13 - Volatile digital starts at preset, steps up/down, preset after power-up
// R14 - Retained digital restores last value after power-up, still adjustable
// R15 - Pulse source measured only on third input, 0 to 100 kHz
// R16 - Full-scale pulse rate maps linearly to maximum frequency
// R17 - Multi-speed decodes four terminals into sixteen stored percentages
// R18 - Each analog input uses one of five selectable curves; select codes 5 to 7 bypass the curves at unity gain
// R19 - Sequencer steps up to sixteen steps, own duration and ramp select
// R20 - Combined targets get the configured offset frequency added
// R21 - Main and auxiliary sources must not share a code; a shared code is only flagged on configError_q
// R22 - Channel 0: run and stop/reset come only from panel buttons
// R23 - Target is clamped to plus or minus maximum frequency
`timescale 1ns/1ns
`include "frs_defs.vh"
module frs_frequency_selector #(
   parameter GATE_CYC = `FRS_GATE_CYC,
   parameter UPDN_CYC = `FRS_UPDN_CYC,
   parameter TICK_CYC = `FRS_SEQ_TICK_CYC
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire [1:0]   commandChannelSelect,
   input  wire [7:0]   frequencySourceCombine,
   input  wire [3:0]   mainSourceSelect,
   input  wire [3:0]   auxSourceSelect,
   input  wire [15:0]  presetFrequency,
   input  wire [15:0]  maximumFrequency,
   input  wire [15:0]  combineOffsetFrequency,
   input  wire         digitalFrequencyRetentionSelect,
   input  wire [5:0]   analogCurveSelect,
   input  wire [15:0]  retainedFrequency,
   input  wire         panelRun,
   input  wire         panelStop,
   input  wire         runForwardInput,
   input  wire         runReverseInput,
   input  wire         jogForwardInput,
   input  wire         jogReverseInput,
   input  wire         hostRun,
   input  wire         hostReverse,
   input  wire         hostStop,
   input  wire         upKey,
   input  wire         downKey,
   input  wire         freqSwitchInput,
   input  wire [3:0]   speedSelectInput,
   input  wire         pulseCapableDigitalInput,
   input  wire [15:0]  voltageAnalogInput,
   input  wire [15:0]  secondAnalogInput,
   input  wire [15:0]  panelKnob,
   input  wire [15:0]  pidOutput,
   input  wire [15:0]  commFrequency,
   input  wire [255:0] multiSpeedTable,
   input  wire [255:0] seqStepTable,
   input  wire [255:0] seqDurationTable,
   input  wire [31:0]  seqRampTable,
   input  wire [3:0]   seqLastStep,
   input  wire [79:0]  curveGain,
   output reg          runCmd_q,
   output reg          reverseCmd_q,
   output reg          jogCmd_q,
   output reg          stopResetCmd_q,
   output reg  [1:0]   seqRampSel_q,
   output reg  [15:0]  digitalFrequency_q,
   output reg          configError_q,
   output reg  [16:0]  targetFrequency_q
);
   reg  [1:0]  syncA;
   reg  [1:0]  syncB;
   reg  [1:0]  syncC;
   reg  [1:0]  syncD;
   reg  [1:0]  syncE;
   reg  [1:0]  syncF;
   reg  [1:0]  syncG;
   reg  [1:0]  syncUp;
   reg  [1:0]  syncDn;
   reg  [1:0]  syncSw;
   reg  [7:0]  syncSpd;
   reg         initDone_q;
   reg  [31:0] updnCnt_q;
   reg  [3:0]  seqIdx_q;
   reg  [31:0] tickCnt_q;
   reg  [15:0] seqTime_q;
   wire [15:0] pulseCount;
   wire        pulseValid;
   reg  [15:0] pulseFreq_q;
   wire [15:0] vaCurved;
   wire [15:0] saCurved;
   wire [15:0] srcVal [0:9];
   wire [3:0]  unitDigit = frequencySourceCombine[3:0];
   wire [3:0]  tensDigit = frequencySourceCombine[7:4];
   wire        swAct     = syncSw[1];
   // Full-scale edge count follows the gate length, so a shortened gate
   // still maps the top rate to maximum frequency; the gate must span
   // at least one period of the top rate
   localparam PULSE_FS = GATE_CYC / (`FRS_CLK_HZ / `FRS_PULSE_MAX_HZ);
   wire [31:0] pulseScaled = ({16'h0, pulseCount} * {16'h0, maximumFrequency}) / PULSE_FS;  // [R16]

   frs_pulse_meter #(
      .GATE_CYC (GATE_CYC)
   ) uPulse (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .pulseIn      (pulseCapableDigitalInput),  // [R15]
      .pulseCount_q (pulseCount),
      .countValid_q (pulseValid)
   );

   // Curve gain in 1/256 steps per curve; one per analog input [R18]
   function [15:0] applyCurve;
      input [15:0] v;
      input [2:0]  sel;
      input [79:0] gains;
      reg   [15:0] g;
      reg   [31:0] p;
      begin
         g = (sel < `FRS_CURVES) ? gains[sel*16 +: 16] : 16'h0100;
         p = v * g;
         applyCurve = (p[31:24] != 8'h0) ? 16'hffff : p[23:8];
      end
   endfunction

   // Scale a 0..10000 (0.01 %) step value to maximum frequency [R17]
   function [15:0] pctOfMax;
      input [15:0] pct;
      input [15:0] fmax;
      reg   [31:0] p;
      reg   [31:0] q;
      begin
         p = pct * fmax;
         q = p / 32'd10000;
         pctOfMax = q[15:0];
      end
   endfunction

   assign vaCurved = applyCurve(voltageAnalogInput, analogCurveSelect[2:0], curveGain);  // [R18]
   assign saCurved = applyCurve(secondAnalogInput, analogCurveSelect[5:3], curveGain);   // [R18]

   // Source code table [R12]
   assign srcVal[0] = digitalFrequency_q;
   assign srcVal[1] = digitalFrequency_q;
   assign srcVal[2] = vaCurved;
   assign srcVal[3] = saCurved;
   assign srcVal[4] = panelKnob;
   assign srcVal[5] = pulseFreq_q;
   assign srcVal[6] = pctOfMax(multiSpeedTable[syncSpd[7:4]*16 +: 16], maximumFrequency);  // [R17]
   assign srcVal[7] = pctOfMax(seqStepTable[seqIdx_q*16 +: 16], maximumFrequency);         // [R19]
   assign srcVal[8] = pidOutput;
   assign srcVal[9] = commFrequency;

   wire [15:0] xVal = (mainSourceSelect <= `FRS_SRC_COMM) ? srcVal[mainSourceSelect] : 16'h0;
   wire [15:0] yVal = (auxSourceSelect <= `FRS_SRC_COMM) ? srcVal[auxSourceSelect] : 16'h0;
   // Spare top bits keep a full-scale sum plus offset from reading as negative
   wire [18:0] xs   = {3'h0, xVal};
   wire [18:0] ys   = {3'h0, yVal};

   // Sources are unsigned here, so the magnitude compare is a plain compare
   reg [18:0] combRaw;
   always @* begin
      case (tensDigit)
         `FRS_OP_ADD: combRaw = xs + ys;                    // [R08]
         `FRS_OP_SUB: combRaw = xs - ys;                    // [R09]
         `FRS_OP_MAX: combRaw = (xVal >= yVal) ? xs : ys;   // [R10]
         `FRS_OP_MIN: combRaw = (xVal <= yVal) ? xs : ys;   // [R11]
         default:     combRaw = xs;
      endcase
   end
   wire [18:0] combVal = combRaw + {3'h0, combineOffsetFrequency};  // [R20]

   reg [18:0] pick;
   always @* begin
      case (unitDigit)
         `FRS_UNIT_X:    pick = xs;                          // [R03]
         `FRS_UNIT_COMB: pick = combVal;                     // [R04]
         `FRS_UNIT_XY:   pick = swAct ? ys : xs;             // [R05]
         `FRS_UNIT_XXY:  pick = swAct ? combVal : xs;        // [R06]
         `FRS_UNIT_YXY:  pick = swAct ? combVal : ys;        // [R07]
         default:        pick = xs;
      endcase
   end

   // Clamp both ways; bit 18 set means the difference went negative [R23]
   wire [18:0] fmax  = {3'h0, maximumFrequency};
   wire        neg   = pick[18];
   wire [18:0] mag   = neg ? (19'h0 - pick) : pick;
   wire [18:0] magC  = (mag > fmax) ? fmax : mag;
   wire [16:0] tgtD  = neg ? (17'h0 - magC[16:0]) : magC[16:0];

   // Both keys held together cancel, so the value neither climbs nor falls
   wire upHold = syncUp[1] & ~syncDn[1];
   wire dnHold = syncDn[1] & ~syncUp[1];

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= 2'h0; syncB <= 2'h0; syncC <= 2'h0; syncD <= 2'h0;
         syncE <= 2'h0; syncF <= 2'h0; syncG <= 2'h0;
         syncUp <= 2'h0; syncDn <= 2'h0; syncSw <= 2'h0; syncSpd <= 8'h0;
         initDone_q         <= 1'b0;
         updnCnt_q          <= 32'h0;
         seqIdx_q           <= 4'h0;
         tickCnt_q          <= 32'h0;
         seqTime_q          <= 16'h0;
         pulseFreq_q        <= 16'h0;
         digitalFrequency_q <= 16'h0;
         runCmd_q           <= 1'b0;
         reverseCmd_q       <= 1'b0;
         jogCmd_q           <= 1'b0;
         stopResetCmd_q     <= 1'b0;
         seqRampSel_q       <= 2'h0;
         configError_q      <= 1'b0;
         targetFrequency_q  <= 17'h0;
      end else begin
         syncA   <= {syncA[0], panelRun};
         syncB   <= {syncB[0], panelStop};
         syncC   <= {syncC[0], runForwardInput};
         syncD   <= {syncD[0], runReverseInput};
         syncE   <= {syncE[0], jogForwardInput};
         syncF   <= {syncF[0], jogReverseInput};
         syncG   <= {syncG[0], hostRun};
         syncUp  <= {syncUp[0], upKey};
         syncDn  <= {syncDn[0], downKey};
         syncSw  <= {syncSw[0], freqSwitchInput};
         syncSpd <= {syncSpd[3:0], speedSelectInput};
         // Each channel owns the command outputs alone
         case (commandChannelSelect)
            `FRS_CH_PANEL: begin  // [R22]
               runCmd_q       <= syncA[1] & ~syncB[1];
               reverseCmd_q   <= 1'b0;
               jogCmd_q       <= 1'b0;
               stopResetCmd_q <= syncB[1];
            end
            `FRS_CH_TERM: begin  // [R01]
               runCmd_q       <= syncC[1] ^ syncD[1];
               reverseCmd_q   <= syncD[1] | (syncF[1] & ~syncE[1]);
               jogCmd_q       <= ~(syncC[1] | syncD[1]) & (syncE[1] ^ syncF[1]);
               stopResetCmd_q <= 1'b0;
            end
            // Stop and reverse come from same-clock host logic, no sync stage
            `FRS_CH_HOST: begin  // [R02]
               runCmd_q       <= syncG[1] & ~hostStop;
               reverseCmd_q   <= hostReverse;
               jogCmd_q       <= 1'b0;
               stopResetCmd_q <= hostStop;
            end
            default: begin
               runCmd_q       <= 1'b0;
               reverseCmd_q   <= 1'b0;
               jogCmd_q       <= 1'b0;
               stopResetCmd_q <= 1'b0;
            end
         endcase
         // Start value caught after reset release, never under reset
         if (!initDone_q) begin
            initDone_q <= 1'b1;
            digitalFrequency_q <= (mainSourceSelect == `FRS_SRC_RETAINED ||
                                   auxSourceSelect == `FRS_SRC_RETAINED)
                                  ? retainedFrequency : presetFrequency;  // [R13] [R14]
         end else if (digitalFrequencyRetentionSelect && !runCmd_q) begin
            digitalFrequency_q <= presetFrequency;
         end else if (upHold || dnHold) begin
            if (updnCnt_q == UPDN_CYC - 1) begin
               updnCnt_q <= 32'h0;
               if (upHold && digitalFrequency_q < maximumFrequency)
                  digitalFrequency_q <= digitalFrequency_q + 16'h1;  // [R13]
               else if (dnHold && digitalFrequency_q != 16'h0)
                  digitalFrequency_q <= digitalFrequency_q - 16'h1;  // [R14]
            end else
               updnCnt_q <= updnCnt_q + 32'h1;
         end else
            updnCnt_q <= 32'h0;
         // Linear map, full scale rate gives maximum frequency [R16]
         if (pulseValid)
            pulseFreq_q <= (pulseCount >= PULSE_FS) ? maximumFrequency : pulseScaled[15:0];
         // Sequencer advances on a slow tick enable
         if (tickCnt_q == TICK_CYC - 1) begin
            tickCnt_q <= 32'h0;
            if (seqTime_q + 16'h1 >= seqDurationTable[seqIdx_q*16 +: 16]) begin
               seqTime_q <= 16'h0;
               seqIdx_q  <= (seqIdx_q >= seqLastStep) ? 4'h0 : seqIdx_q + 4'h1;  // [R19]
            end else
               seqTime_q <= seqTime_q + 16'h1;
         end else
            tickCnt_q <= tickCnt_q + 32'h1;
         seqRampSel_q      <= seqRampTable[seqIdx_q*2 +: 2];  // [R19]
         // Flag only: with a shared code both operands read the same source
         configError_q     <= (mainSourceSelect == auxSourceSelect);  // [R21]
         targetFrequency_q <= tgtD;  // [R23]
      end
   end
endmodule // frs_frequency_selector

//--- tb/frs_selector_checker.sv
// Port-level assertions for the frequency reference selector
`timescale 1ns/1ns
module frs_selector_checker (
   input logic        mclk,
   input logic        rst_n,
   input logic [1:0]  commandChannelSelect,
   input logic [7:0]  frequencySourceCombine,
   input logic [3:0]  mainSourceSelect,
   input logic [3:0]  auxSourceSelect,
   input logic [15:0] maximumFrequency,
   input logic [15:0] combineOffsetFrequency,
   input logic [5:0]  analogCurveSelect,
   input logic [15:0] voltageAnalogInput,
   input logic [15:0] secondAnalogInput,
   input logic        runForwardInput,
   input logic        runReverseInput,
   input logic        runCmd_q,
   input logic        reverseCmd_q,
   input logic        configError_q,
   input logic [16:0] targetFrequency_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Unity curves keep the analog path free of scaling, so sums are exact
   wire               anaXy = rst_n && analogCurveSelect[2:0] >= 3'h5 && analogCurveSelect[5:3] >= 3'h5
                              && mainSourceSelect == 4'h2 && auxSourceSelect == 4'h3;
   wire signed [18:0] fmax = {3'h0, maximumFrequency};
   wire signed [18:0] xVal = {3'h0, voltageAnalogInput};
   wire signed [18:0] sumV = xVal + {3'h0, secondAnalogInput} + {3'h0, combineOffsetFrequency};
   wire signed [18:0] difV = xVal - {3'h0, secondAnalogInput} + {3'h0, combineOffsetFrequency};
   wire signed [18:0] tgt = {{2{targetFrequency_q[16]}}, targetFrequency_q};
   wire               xOk = anaXy && frequencySourceCombine == 8'h00 && xVal <= fmax;
   wire               addOk = anaXy && frequencySourceCombine == 8'h01 && sumV <= fmax;
   wire               subOk = anaXy && frequencySourceCombine == 8'h11 && difV <= fmax && difV >= -fmax;
   wire               sameSel = rst_n && mainSourceSelect == auxSourceSelect;
   wire               chanTerm = commandChannelSelect == 2'h1;

   clamp_range_a: assert property (tgt <= $past(fmax) && tgt >= -$past(fmax))
      else $error("target outside maximum frequency");
   x_alone_a: assert property ($past(xOk) |-> tgt == $past(xVal))
      else $error("target is not main source alone");
   add_op_a: assert property ($past(addOk) |-> tgt == $past(sumV))
      else $error("sum with offset wrong");
   sub_op_a: assert property ($past(subOk) |-> tgt == $past(difV))
      else $error("difference with offset wrong");
   cfg_error_a: assert property (configError_q == $past(sameSel))
      else $error("shared source flag wrong");
   term_run_a: assert property ((chanTerm && runForwardInput && !runReverseInput)[*4] |-> runCmd_q && !reverseCmd_q)
      else $error("forward terminal run missing");
   term_rev_a: assert property ((chanTerm && runReverseInput && !runForwardInput)[*4] |-> runCmd_q && reverseCmd_q)
      else $error("reverse terminal run missing");
   term_idle_a: assert property ((chanTerm && !runForwardInput && !runReverseInput)[*4] |-> !runCmd_q)
      else $error("run without terminal command");
endmodule // frs_selector_checker

bind frs_frequency_selector frs_selector_checker frs_selector_checker_inst (.mclk, .rst_n, .commandChannelSelect,
   .frequencySourceCombine, .mainSourceSelect, .auxSourceSelect, .maximumFrequency, .combineOffsetFrequency,
   .analogCurveSelect, .voltageAnalogInput, .secondAnalogInput, .runForwardInput, .runReverseInput, .runCmd_q,
   .reverseCmd_q, .configError_q, .targetFrequency_q);

//--- tb/frs_far_side.sv
// Model of the input terminals driving the selector pins
`timescale 1ns/1ns
module frs_far_side (
   input  logic       mclk,
   input  logic [3:0] termReq,
   input  logic [3:0] speedReq,
   input  logic       swReq,
   input  logic       upReq,
   input  logic       pulseEn,
   output logic [3:0] termPin,
   output logic [3:0] speedPin,
   output logic       swPin,
   output logic       upPin,
   output logic       pulsePin
);
   logic [7:0] divQ;
   initial begin
      {termPin, speedPin, swPin, upPin, pulsePin, divQ} = 0;
   end
   always @(posedge mclk) begin
      termPin <= termReq;
      speedPin <= speedReq;
      swPin <= swReq;
      upPin <= upReq;
      // Toggle every 250 cycles keeps the rate at 100 kHz, the top of the range
      divQ <= (divQ == 8'hf9) ? 8'h00 : divQ + 8'h01;
      if (divQ == 8'hf9) pulsePin <= pulseEn & ~pulsePin;
   end
endmodule // frs_far_side

//--- tb/frs_frequency_selector_test.sv
// Self-checking bench for the frequency reference selector
`timescale 1ns/1ns
module frs_frequency_selector_test;
   reg          mclk, rstN, panelRun, panelStop, hostRun, hostReverse, hostStop, downKey, upReq, swReq, pulseEn;
   reg          digitalFrequencyRetentionSelect;
   reg  [1:0]   commandChannelSelect;
   reg  [7:0]   frequencySourceCombine;
   reg  [3:0]   mainSourceSelect, auxSourceSelect, termReq, speedReq, seqLastStep;
   reg  [15:0]  presetFrequency, maximumFrequency, combineOffsetFrequency, retainedFrequency;
   reg  [15:0]  voltageAnalogInput, secondAnalogInput, panelKnob, pidOutput, commFrequency, x;
   reg  [5:0]   analogCurveSelect;
   reg  [79:0]  curveGain;
   reg  [31:0]  seqRampTable, seed;
   reg  [255:0] multiSpeedTable, seqStepTable, seqDurationTable;
   wire [3:0]   termPin, speedPin;
   wire         swPin, upPin, pulsePin, runCmd, revCmd, jogCmd, stopCmd;
   wire [1:0]   seqRamp;
   wire [15:0]  digFreq;
   wire [16:0]  target;
   integer      errTotal, nTests, u, t, s, k, e;

   frs_far_side frs_far_side_inst (.mclk, .termReq, .speedReq, .swReq, .upReq, .pulseEn, .termPin, .speedPin,
      .swPin, .upPin, .pulsePin);
   frs_frequency_selector #(.GATE_CYC(2500), .UPDN_CYC(4), .TICK_CYC(4)) frs_frequency_selector_inst (.mclk,
      .rst_n(rstN), .commandChannelSelect, .frequencySourceCombine, .mainSourceSelect, .auxSourceSelect,
      .presetFrequency, .maximumFrequency, .combineOffsetFrequency, .digitalFrequencyRetentionSelect,
      .analogCurveSelect, .retainedFrequency, .panelRun, .panelStop, .runForwardInput(termPin[0]),
      .runReverseInput(termPin[1]), .jogForwardInput(termPin[2]), .jogReverseInput(termPin[3]), .hostRun,
      .hostReverse, .hostStop, .upKey(upPin), .downKey, .freqSwitchInput(swPin), .speedSelectInput(speedPin),
      .pulseCapableDigitalInput(pulsePin), .voltageAnalogInput, .secondAnalogInput, .panelKnob, .pidOutput,
      .commFrequency, .multiSpeedTable, .seqStepTable, .seqDurationTable, .seqRampTable, .seqLastStep, .curveGain,
      .runCmd_q(runCmd), .reverseCmd_q(revCmd), .jogCmd_q(jogCmd), .stopResetCmd_q(stopCmd), .seqRampSel_q(seqRamp),
      .digitalFrequency_q(digFreq), .configError_q(), .targetFrequency_q(target));

   function automatic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   // Reference target: combine, pick by units digit and switch, then clamp
   function automatic int model(int un, int te, int xv, int yv, int sw, int off, int fm);
      int c, r;
      case (te)
         0: c = xv + yv;
         1: c = xv - yv;
         2: c = (xv > yv) ? xv : yv;
         default: c = (xv < yv) ? xv : yv;
      endcase
      c = c + off;
      case (un)
         0: r = xv;
         1: r = c;
         2: r = sw ? yv : xv;
         3: r = sw ? c : xv;
         default: r = sw ? c : yv;
      endcase
      if (r > fm) r = fm;
      if (r < -fm) r = -fm;
      return r;
   endfunction

   task step(input integer n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      nTests = nTests + 1;
      if (seen !== exp) begin
         errTotal = errTotal + 1;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task stopTest;
      $display("checks %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Power cycle, then the stored value must hold and the up key must raise it
   task digCheck(input [15:0] base);
      rstN = 0;
      step(4);
      rstN = 1;
      step(3);
      chk("digStart", digFreq, base);
      upReq = 1;
      step(24);
      upReq = 0;
      step(5);
      chk("digUp", digFreq, base + 16'd6);
      downKey = 1;
      step(8);
      downKey = 0;
      step(4);
      chk("digDown", digFreq, base + 16'd4);
   endtask

   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      errTotal = errTotal + 1;
      stopTest;
   end

   initial begin
      errTotal = 0; nTests = 0; seed = 32'h382f; rstN = 0;
      {panelRun, panelStop, hostRun, hostReverse, hostStop, downKey, upReq, swReq, pulseEn} = 0;
      digitalFrequencyRetentionSelect = 0; commandChannelSelect = 2'h1; frequencySourceCombine = 8'h00;
      mainSourceSelect = 4'h2; auxSourceSelect = 4'h3; termReq = 0; speedReq = 0; seqLastStep = 4'hf;
      presetFrequency = 16'h03e8; maximumFrequency = 16'h2710; combineOffsetFrequency = 0;
      retainedFrequency = 16'h07d0; {voltageAnalogInput, secondAnalogInput, panelKnob, pidOutput, commFrequency} = 0;
      analogCurveSelect = 6'h3f; curveGain = 0; seqRampTable = 0; multiSpeedTable = 0; seqStepTable = 0;
      seqDurationTable = 0;
      step(4);
      rstN = 1;
      step(3);
      for (u = 0; u < 5; u++) for (t = 0; t < 4; t++) for (s = 0; s < 2; s++) for (k = 0; k < 4; k++) begin
         voltageAnalogInput = rnd() & 16'h1fff; secondAnalogInput = rnd() & 16'h1fff;
         panelKnob = rnd() & 16'h1fff; pidOutput = rnd() & 16'h1fff; commFrequency = rnd() & 16'h1fff;
         combineOffsetFrequency = rnd() & 16'h00ff; curveGain = {5{rnd()}}; seqRampTable = {rnd(), rnd()};
         seqStepTable = {16{rnd()}}; seqDurationTable = {16{rnd() & 16'h0003}}; seqLastStep = rnd();
         mainSourceSelect = (k == 0) ? 4'h2 : (k == 1) ? 4'h4 : (k == 2) ? 4'h8 : 4'h9;
         x = (k == 0) ? voltageAnalogInput : (k == 1) ? panelKnob : (k == 2) ? pidOutput : commFrequency;
         frequencySourceCombine = {t[3:0], u[3:0]};
         swReq = s[0];
         step(5);
         e = model(u, t, x, secondAnalogInput, s, combineOffsetFrequency, maximumFrequency);
         chk("target", {15'h0, target}, {15'h0, e[16:0]});
      end
      mainSourceSelect = 4'h3;
      step(2);
      mainSourceSelect = 4'h6; frequencySourceCombine = 8'h00; swReq = 0;
      for (s = 0; s < 16; s++) multiSpeedTable[s * 16 +: 16] = rnd() % 16'd10001;
      for (s = 0; s < 16; s++) begin
         speedReq = s[3:0];
         step(6);
         chk("multiSpeed", {15'h0, target}, {17'h0, multiSpeedTable[s * 16 +: 16]});
      end
      mainSourceSelect = 4'h7; seqLastStep = 4'h0; seqStepTable[15:0] = rnd() % 16'd10001;
      seqRampTable[1:0] = rnd() % 4;
      step(40);
      chk("seqStep", {15'h0, target}, {16'h0, seqStepTable[15:0]});
      chk("seqRamp", {30'h0, seqRamp}, {30'h0, seqRampTable[1:0]});
      mainSourceSelect = 4'h0; presetFrequency = rnd() % 16'd5000;
      digCheck(presetFrequency);
      mainSourceSelect = 4'h1; retainedFrequency = rnd() % 16'd5000;
      digCheck(retainedFrequency);
      mainSourceSelect = 4'h5; pulseEn = 1;
      step(8000);
      chk("pulse", {15'h0, target}, {16'h0, maximumFrequency});
      pulseEn = 0; hostRun = 1; panelRun = 1;
      for (k = 0; k < 5; k++) begin
         termReq = (k == 4) ? 4'h4 : k[3:0];
         step(6);
         chk("run", runCmd, k == 1 || k == 2);
         chk("jog", jogCmd, k == 4);
         if (k == 1 || k == 2) chk("reverse", revCmd, k == 2);
      end
      commandChannelSelect = 2'h2; termReq = 4'h1; panelRun = 0; hostReverse = 1;
      step(6);
      chk("hostRun", runCmd, 1);
      chk("hostRev", revCmd, 1);
      hostRun = 0; hostStop = 1; hostReverse = 0;
      step(6);
      chk("hostStop", runCmd, 0);
      chk("hostStopOut", stopCmd, 1);
      commandChannelSelect = 2'h0; hostStop = 0; hostRun = 1; panelStop = 1;
      step(6);
      chk("panelOnly", runCmd, 0);
      chk("panelStop", stopCmd, 1);
      panelStop = 0; panelRun = 1; hostRun = 0; termReq = 0;
      step(6);
      chk("panelRun", runCmd, 1);
      chk("panelClear", stopCmd, 0);
      stopTest;
   end
endmodule // frs_frequency_selector_test
